// *** src/scr_top.sv ***
// surround compressor router: six channels, four soft-knee compressors
// assumes an ahb-lite master on the same clock, and upstream logic that
// gives one in_valid pulse per sample period with all six samples stable
`timescale 1ns/10ps
`include "scr_defs.svh"

// Notes on behaviour
// [R1] four independent compressors, each with its own settings and side chain
// [R2] each side chain hears a mix of all six input channels
// [R3] each channel picks one of four compressors or bypass
// [R4] ratio 1:1 never changes gain
// [R5] infinite ratio holds every level above threshold at the threshold
// [R6] above threshold output rises with slope one over ratio
// [R7] threshold is relative to full scale, zero or negative
// [R8] gain moves gradually into compression around the threshold
// [R9] attack time sets how fast reduction grows
// [R10] release time sets how fast reduction is withdrawn
// [R11] smoothing low-pass in the control path lengthens attack and release
// [R12] audio path is delayed behind the side chain by a settable amount
// [R13] each compressor shows its present gain reduction for a meter
// [R14] output gain is off or -79.0 to +24.0 dB after compression
// [R15] global engage; disengaged passes everything uncompressed, output gain ignored
// [R16] mix amounts are percentages, six per side chain
// [R17] makeup adds to output gain, together at most 24 dB boost
// [R18] all channels processed each sample period with fixed latency
// [R19] bypassed channels keep the common delay and stay aligned
module scr_top #(
   parameter int DLY_DEPTH = `SCR_PDLY_MAX_US * `SCR_FS_HZ / `SCR_US_PER_S,
   parameter int DW = $clog2(DLY_DEPTH)
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata_ff,
   output logic hreadyout_ff,
   output logic hresp_ff,
   input wire logic in_valid,
   input wire logic [5:0][23:0] in_sample,
   output logic out_valid_ff,
   output logic [5:0][23:0] out_sample_ff,
   output logic [3:0][15:0] meter_ff
);
   // ============================================================
   // control registers
   logic engage_ff;
   logic ogain_off_ff;
   logic [11:0] ogain_ff;
   logic [5:0][2:0] route_ff;
   logic [3:0][11:0] time_ff;
   logic [3:0][8:0] slope_ff;
   logic [3:0][11:0] thr_ff;
   logic [3:0][11:0] mkup_ff;
   logic [3:0] mkup_off_ff;
   logic [3:0][DW-1:0] pdly_ff;
   logic [3:0][5:0][6:0] mix_ff;

   // pipeline state
   logic tick1_ff;
   logic tick2_ff;
   logic [3:0][23:0] sc_lvl_ff;
   logic [3:0][23:0] nxt_sc_lvl;
   logic [3:0][15:0] gr;
   logic [5:0][23:0] dly_out;
   logic [5:0][23:0] nxt_out;

   // ============================================================
   // ahb-lite slave: zero wait states, reads answered from an address-phase
   // snapshot, writes applied at the end of the data phase
   logic wr_pend_ff;
   logic [11:0] wr_addr_ff;

   wire acc = hsel & htrans[1] & hready;
   wire [3:0] wpg = wr_addr_ff[11:8];
   wire [1:0] wcm = wr_addr_ff[7:6];
   wire [3:0] wwd = wr_addr_ff[5:2];
   wire wr_top = wr_pend_ff & (wpg == 4'h0);
   wire wr_cmp = wr_pend_ff & (wpg == `SCR_COMP_PAGE);
   wire [2:0] wmix = 3'(wwd - `SCR_MIX_W);

   // percentages above full scale read and act as 100
   function automatic logic [6:0] pct_c(input logic [6:0] p);
      return (p > `SCR_PCT_MAX) ? `SCR_PCT_MAX : p;
   endfunction

   // gain settings clip to the documented span in tenths of a decibel
   function automatic logic signed [11:0] db_c(input logic signed [11:0] d);
      if (d < $signed(`SCR_DB10_MIN)) begin
         return $signed(`SCR_DB10_MIN);
      end
      return (d > $signed(`SCR_DB10_MAX)) ? $signed(`SCR_DB10_MAX) : d;
   endfunction

   // readback; unmapped words read zero
   function automatic logic [31:0] reg_read(input logic [11:0] a);
      logic [1:0] cm;
      logic [3:0] wd;
      cm = a[7:6];
      wd = a[5:2];
      if (a[11:8] == 4'h0) begin
         case (a)
            `SCR_CTRL_OFS: return {31'h00000000, engage_ff};
            `SCR_OGAIN_OFS: return {15'h0000, ogain_off_ff, 4'h0, ogain_ff};
            `SCR_ROUTE_OFS: return {14'h0000, route_ff};
            default: return 32'h00000000;
         endcase
      end else if (a[11:8] == `SCR_COMP_PAGE && a[1:0] == 2'b00) begin
         if (wd >= `SCR_MIX_W && wd <= `SCR_MIX_LAST_W) begin
            return {25'h0000000, mix_ff[cm][3'(wd - `SCR_MIX_W)]};
         end
         case (wd)
            `SCR_TIME_W: return {20'h00000, time_ff[cm]};
            `SCR_SLOPE_W: return {23'h000000, slope_ff[cm]};
            `SCR_THR_W: return {20'h00000, thr_ff[cm]};
            `SCR_MKUP_W: return {15'h0000, mkup_off_ff[cm], 4'h0, mkup_ff[cm]};
            `SCR_PDLY_W: return {(32 - DW)'(0), pdly_ff[cm]};
            `SCR_METER_W: return {16'h0000, meter_ff[cm]};
            default: return 32'h00000000;
         endcase
      end
      return 32'h00000000;
   endfunction

   // bus handshake; the slave never stalls and always answers okay
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 12'h000;
         hrdata_ff <= 32'h00000000;
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end else begin
         wr_pend_ff <= acc & hwrite;
         wr_addr_ff <= haddr[11:0];
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
         if (acc & ~hwrite) begin
            hrdata_ff <= reg_read(haddr[11:0]);
         end
      end
   end

   // global registers
   always_ff @(posedge clock) begin
      if (rst) begin
         engage_ff <= 1'b0;
         ogain_off_ff <= 1'b0;
         ogain_ff <= 12'h000;
         route_ff <= '0;
      end else if (wr_top) begin
         case (wr_addr_ff)
            `SCR_CTRL_OFS: engage_ff <= hwdata[`SCR_ENGAGE_BIT]; // [R15]
            `SCR_OGAIN_OFS: begin
               ogain_off_ff <= hwdata[`SCR_OFF_BIT];
               ogain_ff <= hwdata[11:0];
            end
            `SCR_ROUTE_OFS: route_ff <= hwdata[17:0]; // [R3]
            default: ;
         endcase
      end
   end

   // compressor page registers, one 64-byte block per section within the one page
   always_ff @(posedge clock) begin
      if (rst) begin
         time_ff <= {4{`SCR_TIME_RST}};
         slope_ff <= {4{`SCR_SLOPE_RST}};
         thr_ff <= {4{`SCR_THR_RST}};
         mkup_ff <= '0;
         mkup_off_ff <= 4'h0;
         pdly_ff <= '0;
         mix_ff <= {24{`SCR_MIX_RST}};
      end else if (wr_cmp) begin
         case (wwd)
            `SCR_TIME_W: time_ff[wcm] <= hwdata[11:0];
            `SCR_SLOPE_W: slope_ff[wcm] <= hwdata[8:0];
            `SCR_THR_W: thr_ff[wcm] <= hwdata[11:0];
            `SCR_MKUP_W: begin
               mkup_off_ff[wcm] <= hwdata[`SCR_OFF_BIT];
               mkup_ff[wcm] <= hwdata[11:0];
            end
            `SCR_PDLY_W: pdly_ff[wcm] <= hwdata[DW-1:0];
            default: begin
               if (wwd >= `SCR_MIX_W && wwd <= `SCR_MIX_LAST_W) begin
                  mix_ff[wcm][wmix] <= pct_c(hwdata[6:0]); // [R16]
               end
            end
         endcase
      end
   end

   // ============================================================
   // side-chain mixers: weighted magnitudes of all six channels
   // the sum is scaled by 1/100 with a 655/65536 product, a hair low
   always_comb begin
      logic [35:0] sum;
      logic [51:0] scl;
      logic [23:0] mag;
      sum = 36'h000000000;
      scl = 52'h0000000000000;
      mag = 24'h000000;
      for (int s = 0; s < 4; s++) begin
         sum = 36'h000000000;
         for (int c = 0; c < 6; c++) begin
            mag = in_sample[c][23] ? 24'(-in_sample[c]) : in_sample[c];
            sum = 36'(sum + 36'(mag) * 36'(pct_c(mix_ff[s][c]))); // [R2]
         end
         scl = 52'(sum) * 52'(`SCR_PCT_SCALE);
         nxt_sc_lvl[s] = (scl[51:16] > 36'h000ffffff) ? 24'hffffff : scl[39:16];
      end
   end

   // one side-chain sample per period; tick stages keep latency fixed
   always_ff @(posedge clock) begin
      if (rst) begin
         tick1_ff <= 1'b0;
         tick2_ff <= 1'b0;
         sc_lvl_ff <= '0;
      end else begin
         tick1_ff <= in_valid; // [R18]
         tick2_ff <= tick1_ff;
         if (in_valid) begin
            sc_lvl_ff <= nxt_sc_lvl;
         end
      end
   end

   // ============================================================
   // four independent compressor sections
   for (genvar s = 0; s < 4; s++) begin : g_comp
      scr_comp u_comp ( // [R1]
         .clock(clock),
         .rst(rst),
         .tick(tick1_ff),
         .level(sc_lvl_ff[s]),
         .thresh_db10(thr_ff[s]),
         .slope(slope_ff[s]),
         .atk_sh(time_ff[s][`SCR_ATK_LSB +: 4]),
         .rel_sh(time_ff[s][`SCR_REL_LSB +: 4]),
         .smth_sh(time_ff[s][`SCR_SMTH_LSB +: 4]),
         .gr_ff(gr[s])
      );
   end

   // ============================================================
   // signal predelay: a channel follows its compressor's setting; bypassed
   // channels take the longest setting so they stay in step with the rest
   wire [DW-1:0] pmax01 = (pdly_ff[0] > pdly_ff[1]) ? pdly_ff[0] : pdly_ff[1];
   wire [DW-1:0] pmax23 = (pdly_ff[2] > pdly_ff[3]) ? pdly_ff[2] : pdly_ff[3];
   wire [DW-1:0] pmax = (pmax01 > pmax23) ? pmax01 : pmax23;

   for (genvar c = 0; c < 6; c++) begin : g_dly
      wire routed = (route_ff[c] != scr_pkg::scr_bypass) && (route_ff[c] <= scr_pkg::scr_comp4);
      wire [1:0] sel = 2'(route_ff[c] - 3'h1);
      wire [DW-1:0] dsel = routed ? pdly_ff[sel] : pmax; // [R19]
      scr_delay #(
         .WIDTH(24),
         .DEPTH(DLY_DEPTH),
         .AW(DW)
      ) u_dly (
         .clock(clock),
         .rst(rst),
         .tick(in_valid),
         .din(in_sample[c]),
         .dly(dsel), // [R12]
         .dout_ff(dly_out[c])
      );
   end

   // ============================================================
   // gain stage: output gain plus makeup, less the selected reduction
   always_comb begin
      logic [2:0] r;
      logic rt;
      logic signed [11:0] db;
      logic signed [15:0] g;
      logic [21:0] lin;
      logic signed [46:0] prod;
      logic signed [30:0] sh;
      r = 3'h0;
      rt = 1'b0;
      db = 12'h000;
      g = 16'h0000;
      lin = 22'h000000;
      prod = 47'h000000000000;
      sh = 31'h00000000;
      for (int c = 0; c < 6; c++) begin
         r = route_ff[c];
         rt = (r != scr_pkg::scr_bypass) && (r <= scr_pkg::scr_comp4);
         db = db_c(ogain_ff); // [R14]
         if (rt && !mkup_off_ff[2'(r - 3'h1)]) begin
            db = 12'(db + db_c(mkup_ff[2'(r - 3'h1)]));
         end
         if (db > $signed(`SCR_DB10_MAX)) begin
            db = $signed(`SCR_DB10_MAX); // [R17]
         end
         g = scr_pkg::db10_to_log(db);
         if (rt) begin
            g = 16'(g - $signed({1'b0, gr[2'(r - 3'h1)][14:0]})); // [R3]
         end
         lin = scr_pkg::exp2_q16(g);
         prod = 47'($signed(dly_out[c])) * $signed({25'h0000000, lin});
         sh = 31'(prod >>> 16);
         if (sh > 31'sh007fffff) begin
            nxt_out[c] = 24'h7fffff;
         end else if (sh < -31'sh00800000) begin
            nxt_out[c] = 24'h800000;
         end else begin
            nxt_out[c] = sh[23:0];
         end
         if (!engage_ff) begin
            nxt_out[c] = dly_out[c]; // [R15]
         end else if (ogain_off_ff) begin
            nxt_out[c] = 24'h000000;
         end
      end
   end

   // outputs and meters move together, three cycles after in_valid
   always_ff @(posedge clock) begin
      if (rst) begin
         out_valid_ff <= 1'b0;
         out_sample_ff <= '0;
         meter_ff <= '0;
      end else begin
         out_valid_ff <= tick2_ff;
         if (tick2_ff) begin
            out_sample_ff <= nxt_out; // [R18]
            meter_ff <= gr; // [R13]
         end
      end
   end
endmodule

// *** src/scr_defs.svh ***
// register map, field positions, reset values and timing figures of the
// surround compressor router; included by the package, the top module, the compressor and the testbench
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// ============================================================
// register map (byte offsets inside the 4 KiB slave window)
`define SCR_CTRL_OFS 12'h000
`define SCR_OGAIN_OFS 12'h004
`define SCR_ROUTE_OFS 12'h008
`define SCR_COMP_PAGE 4'h1
`define SCR_TIME_W 4'h0
`define SCR_SLOPE_W 4'h1
`define SCR_THR_W 4'h2
`define SCR_MKUP_W 4'h3
`define SCR_PDLY_W 4'h4
`define SCR_METER_W 4'h5
`define SCR_MIX_W 4'h6
`define SCR_MIX_LAST_W 4'hb

// ============================================================
// field positions
`define SCR_ENGAGE_BIT 0
`define SCR_OFF_BIT 16
`define SCR_ATK_LSB 0
`define SCR_REL_LSB 4
`define SCR_SMTH_LSB 8
`define SCR_ROUTE_BITS 3

// ============================================================
// reset values
`define SCR_TIME_RST 12'h3a2
`define SCR_SLOPE_RST 9'h080
`define SCR_THR_RST 12'hf38
`define SCR_MIX_RST 7'h64

// ============================================================
// limits and scale factors
`define SCR_PCT_MAX 7'h64
`define SCR_PCT_SCALE 32'h28f
`define SCR_SLOPE_MAX 9'h100
`define SCR_DB10_MIN 12'hcea
`define SCR_DB10_MAX 12'h0f0
`define SCR_DB10_LOG 32'h441
`define SCR_KNEE 18'h00100
`define SCR_KNEE_SH 10

// ============================================================
// timing: longest signal predelay and the sample rate
`define SCR_PDLY_MAX_US 32'h61a8
`define SCR_FS_HZ 32'hbb80
`define SCR_US_PER_S 32'hf4240

`endif

// *** src/scr_pkg.sv ***
// types and shared level arithmetic of the surround compressor router
// levels are log2 units in q8 relative to digital full scale
package scr_pkg;
`include "scr_defs.svh"

   typedef logic signed [23:0] scr_sample_t;
   typedef logic signed [15:0] scr_log_t;
   typedef enum logic [2:0] {
      scr_bypass = 3'b000,
      scr_compressor_one = 3'b001,
      scr_comp2 = 3'b010,
      scr_comp3 = 3'b011,
      scr_comp4 = 3'b100
   } scr_route_e;

   // magnitude to log2 q8 re full scale; fraction is linear between octaves
   function automatic scr_log_t log2_fs(input logic [23:0] m);
      int p;
      logic [23:0] nrm;
      p = 0;
      for (int i = 0; i < 24; i++) begin
         if (m[i]) begin
            p = i;
         end
      end
      nrm = m << (23 - p);
      if (m == 24'h000000) begin
         return 16'she800;
      end
      return scr_log_t'(16'((p - 23) * 256 + int'(nrm[22:15])));
   endfunction

   // tenths of a decibel to log2 q8
   function automatic scr_log_t db10_to_log(input logic signed [11:0] d);
      int t;
      t = int'(d) * int'(`SCR_DB10_LOG);
      return scr_log_t'(16'(t >>> 8));
   endfunction

   // log2 q8 to linear gain q16, saturated to 22 bits (about +36 dB)
   function automatic logic [21:0] exp2_q16(input scr_log_t g);
      int n;
      logic [31:0] t;
      n = int'(g >>> 8) + 8;
      t = {23'h000000, 1'b1, g[7:0]};
      if (n < -9) begin
         t = 32'h00000000;
      end else if (n < 0) begin
         t = t >> (-n);
      end else if (n > 12) begin
         t = 32'h003fffff;
      end else begin
         t = t << n;
      end
      return (t > 32'h003fffff) ? 22'h3fffff : t[21:0];
   endfunction
endpackage

// *** src/scr_delay.sv ***
// one channel of signal predelay: a circular store of flip-flops
// assumes tick is a one-cycle pulse per sample period on the same clock
`timescale 1ns/10ps
module scr_delay #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 1200,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic tick,
   input wire logic [WIDTH-1:0] din,
   input wire logic [AW-1:0] dly,
   output logic [WIDTH-1:0] dout_ff
);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [DEPTH-1:0][WIDTH-1:0] mem_ff;
   logic [AW-1:0] wptr_ff;

   // requested delay clamps to one less than the store size; read index wraps
   wire [AW-1:0] dly_c = (dly > LAST) ? LAST : dly;
   wire [AW-1:0] rd_idx = (wptr_ff >= dly_c) ? AW'(wptr_ff - dly_c) : AW'(wptr_ff + AW'(DEPTH) - dly_c);

   // zero delay takes the fresh sample, so bypassed timing stays exact
   always_ff @(posedge clock) begin
      if (rst) begin
         mem_ff <= '0;
         wptr_ff <= '0;
         dout_ff <= '0;
      end else if (tick) begin
         mem_ff[wptr_ff] <= din;
         wptr_ff <= (wptr_ff == LAST) ? '0 : AW'(wptr_ff + 1'b1);
         dout_ff <= (dly_c == '0) ? din : mem_ff[rd_idx];
      end
   end
endmodule

// *** src/scr_comp.sv ***
// one soft-knee compressor section: detector, static curve, ballistics
// assumes level is the side-chain magnitude, full scale at 2**23
`timescale 1ns/10ps
`include "scr_defs.svh"
module scr_comp (
   input wire logic clock,
   input wire logic rst,
   input wire logic tick,
   input wire logic [23:0] level,
   input wire logic [11:0] thresh_db10,
   input wire logic [8:0] slope,
   input wire logic [3:0] atk_sh,
   input wire logic [3:0] rel_sh,
   input wire logic [3:0] smth_sh,
   output logic [15:0] gr_ff
);
   logic [15:0] env_ff;

   // one-pole step toward a target; never stalls short of it
   function automatic logic [15:0] step_to(input logic [15:0] cur, input logic [15:0] tgt,
                                          input logic [3:0] sh);
      logic [15:0] d;
      d = (tgt > cur) ? 16'(tgt - cur) : 16'(cur - tgt);
      d = d >> sh;
      if (d == 16'h0000 && tgt != cur) begin
         d = 16'h0001;
      end
      return (tgt > cur) ? 16'(cur + d) : 16'(cur - d);
   endfunction

   // threshold re full scale; positive settings read as 0 dBFS
   wire signed [11:0] thr_c = thresh_db10[11] ? thresh_db10 : 12'h000; // [R7]
   wire signed [17:0] over = 18'(scr_pkg::log2_fs(level)) - 18'(scr_pkg::db10_to_log(thr_c));
   wire signed [17:0] knee_lo = -18'(`SCR_KNEE);
   wire signed [17:0] knee_hi = 18'(`SCR_KNEE);
   wire [17:0] kx = 18'(over + knee_hi);
   // quadratic blend over +-one octave; signed compare keeps negatives below the knee out
   wire [35:0] kq = 36'(kx) * 36'(kx);
   wire [17:0] eff_over = (over <= knee_lo) ? 18'h00000 : (over >= knee_hi) ? over : 18'(kq >> `SCR_KNEE_SH); // [R8]

   // reduction = excess * (1 - 1/ratio); slope 0 is 1:1, 256 is infinite
   wire [8:0] slope_c = (slope > `SCR_SLOPE_MAX) ? `SCR_SLOPE_MAX : slope;
   wire [26:0] gr_raw = 27'(eff_over) * 27'(slope_c); // [R4] [R5] [R6]
   wire [15:0] target = (gr_raw[26:8] > 19'h0ffff) ? 16'hffff : gr_raw[23:8];

   // attack governs rising reduction, release falling; smoothing follows
   always_ff @(posedge clock) begin
      if (rst) begin
         env_ff <= 16'h0000;
         gr_ff <= 16'h0000;
      end else if (tick) begin
         env_ff <= step_to(env_ff, target, (target > env_ff) ? atk_sh : rel_sh); // [R9] [R10]
         gr_ff <= step_to(gr_ff, env_ff, smth_sh); // [R11]
      end
   end
endmodule

// *** verif/scr_top_monitor.sv ***
// checker: timing relations at the router's bus and sample stream ports
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/10ps
module scr_top_monitor (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata_ff,
   input wire logic hreadyout_ff,
   input wire logic hresp_ff,
   input wire logic in_valid,
   input wire logic out_valid_ff,
   input wire logic [5:0][23:0] out_sample_ff,
   input wire logic [3:0][15:0] meter_ff
);
   // ==========
   // read address phases; read data may only move on one of these
   wire logic rd_take;
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   // ==========
   // stream timing
   chk_stream_latency: assert property (in_valid |-> ##3 out_valid_ff)
      else $error("output pulse missing three cycles after input");
   chk_no_stray_out: assert property (out_valid_ff |-> $past(in_valid, 3))
      else $error("output pulse without an input three cycles before");
   chk_out_single_pulse: assert property (out_valid_ff |=> !out_valid_ff)
      else $error("output pulse longer than one cycle");
   chk_samples_hold: assert property (!out_valid_ff |-> $stable(out_sample_ff))
      else $error("output samples moved between pulses");
   chk_meter_hold: assert property (!out_valid_ff |-> $stable(meter_ff))
      else $error("meter moved between output pulses");
   // ==========
   // register bus: no wait states, always okay, read data stands
   chk_ready_always: assert property (hreadyout_ff)
      else $error("slave inserted a wait state");
   chk_resp_okay: assert property (!hresp_ff)
      else $error("slave gave an error response");
   chk_rdata_stands: assert property (!rd_take |=> $stable(hrdata_ff))
      else $error("read data changed without a read request");
endmodule

// *** verif/scr_stream_model.sv ***
// stream model: upstream sample source and downstream capture
// assumes the router answers each sample within a few clock cycles
`timescale 1ns/10ps
module scr_stream_model (
   input wire logic clock,
   input wire logic out_valid_ff,
   input wire logic [5:0][23:0] out_sample_ff,
   output logic in_valid,
   output logic [5:0][23:0] in_sample
);
   logic [5:0][23:0] got;
   // idle until the bench asks for a sample
   initial begin
      in_valid = 1'b0;
      in_sample = '0;
   end
   // one sample period: a single valid pulse, then capture the result
   task automatic send(input logic [5:0][23:0] smp);
      int n = 0;
      @(posedge clock);
      in_valid <= 1'b1;
      in_sample <= smp;
      @(posedge clock);
      in_valid <= 1'b0;
      in_sample <= ~smp; // stale data must never be taken again
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (out_valid_ff !== 1'b1 && n < 6);
      got = out_sample_ff;
   endtask
endmodule

// *** verif/tb.sv ***
// testbench: register, pass-through, predelay and compression scenarios
// assumes design, monitor and stream model are compiled before this file
`timescale 1ns/10ps
`include "scr_defs.svh"
module tb;
   logic clock, rst, hsel, hwrite, in_valid, out_valid_ff, hreadyout_ff, hresp_ff;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata_ff, rd;
   logic [5:0][23:0] in_sample, out_sample_ff, s, a;
   logic [3:0][15:0] meter_ff;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   // short predelay store keeps the run small
   scr_top #(.DLY_DEPTH(16)) uut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_ff), .hrdata_ff(hrdata_ff),
      .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .in_valid(in_valid), .in_sample(in_sample),
      .out_valid_ff(out_valid_ff), .out_sample_ff(out_sample_ff), .meter_ff(meter_ff));
   scr_stream_model src (.clock(clock), .out_valid_ff(out_valid_ff), .out_sample_ff(out_sample_ff),
      .in_valid(in_valid), .in_sample(in_sample));
   // ==========
   // clock and hang guard
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         tally_and_finish();
      end
   end
   // ==========
   // shared tasks
   task automatic tally_and_finish();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] e);
      checks++;
      if (got !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED at %0t: %h outside %h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic cmp_all(input logic [5:0][23:0] e);
      for (int c = 0; c < 6; c++) begin
         cmp({8'h0, src.got[c]}, {8'h0, e[c]});
      end
   endtask
   // single ahb-lite transfer; read data is taken at the data phase edge
   task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= ad;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clock); while (hreadyout_ff !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout_ff !== 1'b1);
      rd = hrdata_ff;
   endtask
   task automatic rdchk(input logic [31:0] ad, input logic [31:0] e);
      bus(1'b0, ad, 32'h0);
      cmp(rd, e);
   endtask
   function automatic logic [31:0] ca(input int k, input logic [3:0] w);
      return 32'h100 + 32'(k) * 32'h40 + {26'h0, w, 2'h0};
   endfunction
   function automatic logic [5:0][23:0] smp(input logic [23:0] x, input logic [23:0] y, input logic [23:0] o);
      logic [5:0][23:0] r = {6{o}};
      r[0] = x;
      r[1] = y;
      return r;
   endfunction
   // ==========
   // scenarios
   // reset values, clamping on write, unmapped read
   task automatic t_regs();
      rdchk({20'h0, `SCR_CTRL_OFS}, 32'h0);
      rdchk({20'h0, `SCR_ROUTE_OFS}, 32'h0);
      rdchk(ca(0, `SCR_TIME_W), 32'h3a2);
      rdchk(ca(1, `SCR_THR_W), 32'hf38);
      rdchk(ca(2, `SCR_MIX_LAST_W), 32'h64);
      rdchk(ca(0, `SCR_METER_W), 32'h0);
      rdchk(32'h0fc, 32'h0);
      bus(1'b1, ca(1, `SCR_MIX_W), 32'h7f);
      rdchk(ca(1, `SCR_MIX_W), 32'h64);
      bus(1'b1, ca(3, `SCR_SLOPE_W), 32'h1ff);
      rdchk(ca(3, `SCR_SLOPE_W), 32'h1ff);
      rdchk(ca(2, `SCR_SLOPE_W), 32'h80);
      bus(1'b1, ca(2, `SCR_THR_W), 32'h64);
      rdchk(ca(2, `SCR_THR_W), 32'h64);
   endtask
   // engage switch against the output gain off state
   task automatic t_engage();
      s = smp(24'h123456, 24'hedcba9, 24'h000777);
      src.send(s);
      cmp_all(s);
      bus(1'b1, {20'h0, `SCR_OGAIN_OFS}, 32'h10000);
      src.send(s);
      cmp_all(s);
      bus(1'b1, {20'h0, `SCR_CTRL_OFS}, 32'h1);
      src.send(s);
      cmp_all('0);
      bus(1'b1, {20'h0, `SCR_OGAIN_OFS}, 32'h0);
      src.send(s);
      cmp_all(s);
   endtask
   // bypassed channels follow the longest predelay, counted in samples
   task automatic t_delay();
      a = smp(24'h0abcde, 24'h765432, 24'h000111);
      bus(1'b1, ca(1, `SCR_PDLY_W), 32'h2);
      src.send(a);
      src.send(s);
      src.send(s);
      cmp_all(a);
      bus(1'b1, ca(1, `SCR_PDLY_W), 32'h0);
   endtask
   // ratio sweep on compressor one, channel two left in bypass
   task automatic t_ratio();
      bus(1'b1, {20'h0, `SCR_ROUTE_OFS}, 32'h9241);
      bus(1'b1, ca(0, `SCR_TIME_W), 32'h0);
      bus(1'b1, ca(0, `SCR_SLOPE_W), 32'h0);
      s = smp(24'h400000, 24'h001234, 24'h0);
      repeat (2) src.send(s);
      cmp({8'h0, src.got[0]}, 32'h400000);
      cmp({16'h0, meter_ff[0]}, 32'h0);
      cmp({8'h0, src.got[1]}, 32'h1234);
      bus(1'b1, ca(0, `SCR_SLOPE_W), 32'h100);
      repeat (2) src.send(s);
      rng({8'h0, src.got[0]}, 32'h80000, 32'h140000);
      rng({16'h0, meter_ff[0]}, 32'h100, 32'h400);
      cmp({8'h0, src.got[1]}, 32'h1234);
      bus(1'b1, ca(0, `SCR_SLOPE_W), 32'h80);
      repeat (2) src.send(s);
      rng({8'h0, src.got[0]}, 32'h180000, 32'h280000);
      bus(1'b1, ca(0, `SCR_MIX_W), 32'h0);
      repeat (2) src.send(s);
      cmp({8'h0, src.got[0]}, 32'h400000);
      bus(1'b1, ca(0, `SCR_MIX_W), 32'h64);
   endtask
   // slow attack builds reduction gradually, slow release holds it
   task automatic t_ballistics();
      a = smp(24'h000100, 24'h0, 24'h0);
      bus(1'b1, ca(0, `SCR_SLOPE_W), 32'h100);
      src.send(a);
      cmp({16'h0, meter_ff[0]}, 32'h0);
      bus(1'b1, ca(0, `SCR_TIME_W), 32'h63);
      repeat (2) src.send(s);
      rng({16'h0, meter_ff[0]}, 32'h1, 32'hff);
      repeat (40) src.send(s);
      rng({16'h0, meter_ff[0]}, 32'h180, 32'h300);
      src.send(a);
      rng({16'h0, meter_ff[0]}, 32'h180, 32'h300);
   endtask
   // ==========
   // main sequence
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_engage();
      t_delay();
      t_ratio();
      t_ballistics();
      tally_and_finish();
   end
endmodule
bind scr_top scr_top_monitor mon (.clock(clock), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
   .in_valid(in_valid), .out_valid_ff(out_valid_ff), .out_sample_ff(out_sample_ff), .meter_ff(meter_ff));
